// >>> src/tmr8_pkg.sv
/*
  Package for the 8-bit timer/counter block: register offsets, field
  positions, reset values, clock-select codes, waveform modes and bus types.
  Assumes a 32-bit APB bus with word-aligned registers.
*/
package tmr8_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] TMR8_OFS_CTRL_A  = 8'h00;
  localparam logic [7:0] TMR8_OFS_CTRL_B  = 8'h04;
  localparam logic [7:0] TMR8_OFS_COUNT   = 8'h08;
  localparam logic [7:0] TMR8_OFS_CMP_A   = 8'h0C;
  localparam logic [7:0] TMR8_OFS_CMP_B   = 8'h10;
  localparam logic [7:0] TMR8_OFS_MASK    = 8'h14;
  localparam logic [7:0] TMR8_OFS_FLAGS   = 8'h18;
  localparam logic [7:0] TMR8_OFS_ACK     = 8'h1C;
  localparam logic [7:0] TMR8_OFS_GIE     = 8'h20;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int TMR8_B_FORCE_A = 7;
  localparam int TMR8_B_FORCE_B = 6;
  localparam int TMR8_B_WAVE_HI = 3;
  localparam int TMR8_A_MODE_A  = 6;
  localparam int TMR8_A_MODE_B  = 4;
  localparam int TMR8_IRQ_CMP_B = 2;
  localparam int TMR8_IRQ_CMP_A = 1;
  localparam int TMR8_IRQ_OVF   = 0;

  // ----------------------------------------------------------------
  // Reset values and constants
  // ----------------------------------------------------------------
  localparam logic [7:0] TMR8_RST_BYTE  = 8'h00;
  localparam logic [7:0] TMR8_MAX       = 8'hFF;
  localparam logic [7:0] TMR8_BOTTOM    = 8'h00;
  localparam logic [7:0] TMR8_ONE       = 8'h01;
  localparam logic [7:0] TMR8_CTRL_B_RD = 8'h0F;
  localparam logic [7:0] TMR8_CTRL_A_RD = 8'hF3;
  localparam logic [2:0] TMR8_IRQ_RD    = 3'h7;
  localparam logic [9:0] TMR8_PRE_ZERO  = 10'h000;
  localparam logic [9:0] TMR8_PRE_ONE   = 10'h001;
  localparam logic [9:0] TMR8_DIV8_M    = 10'h007;
  localparam logic [9:0] TMR8_DIV64_M   = 10'h03F;
  localparam logic [9:0] TMR8_DIV256_M  = 10'h0FF;
  localparam logic [9:0] TMR8_DIV1024_M = 10'h3FF;

  // Clock-select codes
  typedef enum logic [2:0] {
    TMR8_CS_STOP = 3'h0, TMR8_CS_DIV1 = 3'h1, TMR8_CS_DIV8 = 3'h2, TMR8_CS_DIV64 = 3'h3,
    TMR8_CS_DIV256 = 3'h4, TMR8_CS_DIV1024 = 3'h5, TMR8_CS_EXT_FALL = 3'h6,
    TMR8_CS_EXT_RISE = 3'h7
  } tmr8_cs_e;

  // Waveform modes {wave_mode_hi, wave_mode_lo}
  typedef enum logic [2:0] {
    TMR8_WM_NORMAL = 3'h0, TMR8_WM_PC_FF = 3'h1, TMR8_WM_CLR_MATCH = 3'h2, TMR8_WM_FAST_FF = 3'h3,
    TMR8_WM_RSV4 = 3'h4, TMR8_WM_PC_CMP = 3'h5, TMR8_WM_RSV6 = 3'h6, TMR8_WM_FAST_CMP = 3'h7
  } tmr8_wm_e;

  // Output-mode actions
  localparam logic [1:0] TMR8_OM_OFF    = 2'h0;
  localparam logic [1:0] TMR8_OM_TOGGLE = 2'h1;
  localparam logic [1:0] TMR8_OM_CLEAR  = 2'h2;
  localparam logic [1:0] TMR8_OM_SET    = 2'h3;

  // APB request and answer
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } tmr8_apb_req_s;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } tmr8_apb_rsp_s;

  // Waveform pin group
  typedef struct packed {
    logic outA;
    logic outB;
    logic enA;
    logic enB;
  } tmr8_wave_s;

endpackage

// >>> src/tmr8_timer.sv
/*
  8-bit timer/counter: control registers, counter, two compare channels,
  interrupt mask and flags, prescaler and external count input.
  Assumes extCountPin is synchronous to mclk and the CPU interrupt logic
  returns one-cycle vector acknowledges.
*/
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// RULE1 - Force bit triggers immediate compare action
// RULE2 - Forced compare sets no flag, no clear
// RULE3 - Force bits always read back zero
// RULE4 - Software keeps force bits zero in PWM
// RULE5 - Force bits ignored in PWM modes
// RULE6 - Reserved bits read as zero
// RULE7 - Clock select: stop, /1,/8,/64,/256,/1024
// RULE8 - Codes 6/7 count falling/rising pin edges
// RULE9 - Pin edges count even when pin output
// RULE10 - Counter readable and writable directly
// RULE11 - Counter write blocks next timer-clock match
// RULE12 - Both compare registers compared continuously
// RULE13 - Interrupt needs enable, flag and global bit
// RULE14 - Matches set compare flags
// RULE15 - Vector execution clears its flag
// RULE16 - Writing one clears a flag
// RULE17 - Overflow flag set per waveform mode
// RULE18 - Mode bits select normal, match, PWM types
// RULE19 - Output mode: off, toggle, clear, set
// RULE20 - Set wins over simultaneous clear
module tmr8_timer (
  input  wire logic                   mclk,
  input  wire logic                   srst,
  input  wire tmr8_pkg::tmr8_apb_req_s apbReq,
  output var  tmr8_pkg::tmr8_apb_rsp_s apbRsp,
  input  wire logic                   extCountPin,
  input  wire logic [2:0]             irqAck,
  output var  tmr8_pkg::tmr8_wave_s    wave,
  output var  logic [2:0]             irqReq
);
  import tmr8_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]    ctrlA;     // out_mode_a, out_mode_b, wave_mode_lo
    logic [7:0]    ctrlB;     // wave_mode_hi, clk_src_sel
    logic [7:0]    count;
    logic [7:0]    cmpA;
    logic [7:0]    cmpB;
    logic [2:0]    mask;
    logic [2:0]    flags;
    logic          gie;
    logic          upDown;    // 1 while counting down
    logic          blockNext; // match suppression armed
    logic [9:0]    pre;
    logic          pinLast;
    tmr8_apb_rsp_s rsp;
    tmr8_wave_s    wv;
    logic [2:0]    irq;
  } tmr8_state_s;

  tmr8_state_s st;
  tmr8_state_s next_st;

  // Waveform mode from both control registers
  function automatic tmr8_wm_e waveMode(input logic [7:0] a, input logic [7:0] b);
    waveMode = tmr8_wm_e'({b[TMR8_B_WAVE_HI], a[1:0]});
  endfunction

  // True for PWM waveform modes
  function automatic logic isPwm(input tmr8_wm_e m);
    isPwm = (m != TMR8_WM_NORMAL) && (m != TMR8_WM_CLR_MATCH) && (m != TMR8_WM_RSV4)
            && (m != TMR8_WM_RSV6);
  endfunction

  // Output action for a compare event
  function automatic logic compareAct(input logic [1:0] om, input logic cur);
    unique case (om)
      TMR8_OM_TOGGLE: compareAct = ~cur;
      TMR8_OM_CLEAR:  compareAct = 1'b0;
      TMR8_OM_SET:    compareAct = 1'b1;
      default:        compareAct = cur;
    endcase
  endfunction

  // PWM level: high while matching path says so
  function automatic logic pwmAct(input logic [1:0] om, input logic cur, input logic down);
    pwmAct = om[0] ^ down ? 1'b1 : 1'b0;
    if (om == TMR8_OM_OFF || om == TMR8_OM_TOGGLE) begin
      pwmAct = cur;
    end
  endfunction

  logic          wr;
  logic          rd;
  logic          tick;
  logic [7:0]    top;
  tmr8_wm_e      wm;
  tmr8_cs_e      cs;
  logic          matchA;
  logic          matchB;
  logic          atTop;
  logic          pc;
  logic          fast;
  logic [2:0]    setEv;
  logic [2:0]    clrEv;
  logic [7:0]    rdData;
  logic          mapped;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    wr = apbReq.psel && apbReq.penable && apbReq.pwrite;
    rd = apbReq.psel && !apbReq.penable && !apbReq.pwrite;
    wm = waveMode(st.ctrlA, st.ctrlB);
    cs = tmr8_cs_e'(st.ctrlB[2:0]);
    pc = (wm == TMR8_WM_PC_FF) || (wm == TMR8_WM_PC_CMP);
    fast = (wm == TMR8_WM_FAST_FF) || (wm == TMR8_WM_FAST_CMP);
    top = (wm == TMR8_WM_CLR_MATCH || wm == TMR8_WM_PC_CMP || wm == TMR8_WM_FAST_CMP)
          ? st.cmpA : TMR8_MAX;
    atTop = (st.count == top);

    // Prescaler and clock select
    next_st.pre = st.pre + TMR8_PRE_ONE;
    next_st.pinLast = extCountPin;                                 // RULE9
    unique case (cs)                                               // RULE7
      TMR8_CS_STOP:     tick = 1'b0;
      TMR8_CS_DIV1:     tick = 1'b1;
      TMR8_CS_DIV8:     tick = (st.pre & TMR8_DIV8_M) == TMR8_PRE_ZERO;
      TMR8_CS_DIV64:    tick = (st.pre & TMR8_DIV64_M) == TMR8_PRE_ZERO;
      TMR8_CS_DIV256:   tick = (st.pre & TMR8_DIV256_M) == TMR8_PRE_ZERO;
      TMR8_CS_DIV1024:  tick = (st.pre & TMR8_DIV1024_M) == TMR8_PRE_ZERO;
      TMR8_CS_EXT_FALL: tick = st.pinLast && !extCountPin;         // RULE8
      TMR8_CS_EXT_RISE: tick = !st.pinLast && extCountPin;         // RULE8
    endcase

    // Continuous compare, blocked after a counter write
    matchA = tick && !st.blockNext && (st.count == st.cmpA);      // RULE12 RULE11
    matchB = tick && !st.blockNext && (st.count == st.cmpB);      // RULE12 RULE11
    if (tick) begin
      next_st.blockNext = 1'b0;
    end

    // Counter sequence per waveform mode
    setEv = 3'h0;
    if (tick) begin                                                // RULE18
      if (pc) begin
        if (!st.upDown && atTop) begin
          next_st.upDown = 1'b1;
          next_st.count = st.count - TMR8_ONE;
        end else if (st.upDown && st.count == TMR8_BOTTOM) begin
          next_st.upDown = 1'b0;
          next_st.count = st.count + TMR8_ONE;
          setEv[TMR8_IRQ_OVF] = 1'b1;                              // RULE17
        end else begin
          next_st.count = st.upDown ? st.count - TMR8_ONE : st.count + TMR8_ONE;
        end
      end else begin
        next_st.upDown = 1'b0;
        next_st.count = atTop ? TMR8_BOTTOM : st.count + TMR8_ONE;
        if (wm == TMR8_WM_FAST_CMP) begin
          setEv[TMR8_IRQ_OVF] = atTop;                             // RULE17
        end else begin
          setEv[TMR8_IRQ_OVF] = (st.count == TMR8_MAX);            // RULE17
        end
      end
    end
    setEv[TMR8_IRQ_CMP_A] = matchA;                                // RULE14
    setEv[TMR8_IRQ_CMP_B] = matchB;                                // RULE14

    // Waveform outputs
    next_st.wv.enA = st.ctrlA[TMR8_A_MODE_A +: 2] != TMR8_OM_OFF;
    next_st.wv.enB = st.ctrlA[TMR8_A_MODE_B +: 2] != TMR8_OM_OFF;
    if (!isPwm(wm)) begin
      if (matchA) begin                                            // RULE19
        next_st.wv.outA = compareAct(st.ctrlA[TMR8_A_MODE_A +: 2], st.wv.outA);
      end
      if (matchB) begin
        next_st.wv.outB = compareAct(st.ctrlA[TMR8_A_MODE_B +: 2], st.wv.outB);
      end
    end else if (tick) begin
      if (fast && atTop) begin
        next_st.wv.outA = pwmAct(st.ctrlA[TMR8_A_MODE_A +: 2], st.wv.outA, 1'b1);
        next_st.wv.outB = pwmAct(st.ctrlA[TMR8_A_MODE_B +: 2], st.wv.outB, 1'b1);
      end
      // Fast modes only count up, so a match acts as an up-counting match
      if (matchA) begin
        next_st.wv.outA = pwmAct(st.ctrlA[TMR8_A_MODE_A +: 2], st.wv.outA, st.upDown);
      end
      if (matchB) begin
        next_st.wv.outB = pwmAct(st.ctrlA[TMR8_A_MODE_B +: 2], st.wv.outB, st.upDown);
      end
    end

    // Register writes; force strobes are not stored
    clrEv = irqAck;                                                // RULE15
    if (wr) begin
      unique case (apbReq.paddr)
        TMR8_OFS_CTRL_A: next_st.ctrlA = apbReq.pwdata[7:0] & TMR8_CTRL_A_RD;
        TMR8_OFS_CTRL_B: begin
          next_st.ctrlB = apbReq.pwdata[7:0] & TMR8_CTRL_B_RD;     // RULE3 RULE6
          if (!isPwm(wm)) begin                                    // RULE5
            // Forced event changes the pin only: no flag, no clear
            if (apbReq.pwdata[TMR8_B_FORCE_A]) begin               // RULE1 RULE2
              next_st.wv.outA = compareAct(st.ctrlA[TMR8_A_MODE_A +: 2], st.wv.outA);
            end
            if (apbReq.pwdata[TMR8_B_FORCE_B]) begin               // RULE1 RULE2
              next_st.wv.outB = compareAct(st.ctrlA[TMR8_A_MODE_B +: 2], st.wv.outB);
            end
          end
        end
        TMR8_OFS_COUNT: begin
          next_st.count = apbReq.pwdata[7:0];                      // RULE10
          next_st.blockNext = 1'b1;                                // RULE11
        end
        TMR8_OFS_CMP_A: next_st.cmpA = apbReq.pwdata[7:0];
        TMR8_OFS_CMP_B: next_st.cmpB = apbReq.pwdata[7:0];
        TMR8_OFS_MASK:  next_st.mask = apbReq.pwdata[2:0];
        TMR8_OFS_FLAGS: clrEv = clrEv | apbReq.pwdata[2:0];        // RULE16
        TMR8_OFS_GIE:   next_st.gie = apbReq.pwdata[0];
        default: ;
      endcase
    end
    next_st.flags = (st.flags & ~clrEv) | setEv;                   // RULE20
    next_st.irq = st.flags & st.mask & {3{st.gie}};                // RULE13

    // Read path, captured in setup so the access phase answers at once
    mapped = 1'b1;
    unique case (apbReq.paddr)
      TMR8_OFS_CTRL_A: rdData = st.ctrlA;
      TMR8_OFS_CTRL_B: rdData = st.ctrlB & TMR8_CTRL_B_RD;        // RULE3 RULE6
      TMR8_OFS_COUNT:  rdData = st.count;                          // RULE10
      TMR8_OFS_CMP_A:  rdData = st.cmpA;
      TMR8_OFS_CMP_B:  rdData = st.cmpB;
      TMR8_OFS_MASK:   rdData = {5'h00, st.mask & TMR8_IRQ_RD};   // RULE6
      TMR8_OFS_FLAGS:  rdData = {5'h00, st.flags & TMR8_IRQ_RD};  // RULE6
      TMR8_OFS_GIE:    rdData = {7'h00, st.gie};
      default: begin
        rdData = TMR8_RST_BYTE;
        mapped = 1'b0;
      end
    endcase
    next_st.rsp.pready = apbReq.psel && !apbReq.penable;
    next_st.rsp.pslverr = apbReq.psel && !apbReq.penable && !mapped;
    next_st.rsp.prdata = rd ? {24'h000000, rdData} : 32'h00000000;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign apbRsp = st.rsp;
  assign wave   = st.wv;
  assign irqReq = st.irq;

endmodule // tmr8_timer

`default_nettype wire

// >>> verification/tmr8_checker.sv
/* Port assertions for the 8-bit timer block.
   Assumes one clock mclk and a synchronous reset srst. */
`timescale 1ns/1ps
`default_nettype none
module tmr8_checker (
  input wire logic                    mclk,
  input wire logic                    srst,
  input wire tmr8_pkg::tmr8_apb_req_s apbReq,
  input wire tmr8_pkg::tmr8_apb_rsp_s apbRsp,
  input wire logic                    extCountPin,
  input wire logic [2:0]              irqAck,
  input wire tmr8_pkg::tmr8_wave_s    wave,
  input wire logic [2:0]              irqReq
);
  import tmr8_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  logic setup;
  logic rdSetup;
  // ----------------------------------------
  // Bus answer, read-back and output enable
  // ----------------------------------------
  // Setup cycle and read setup cycle
  assign setup   = apbReq.psel && !apbReq.penable;
  assign rdSetup = setup && !apbReq.pwrite;
  chk_ready_follows: assert property (setup |=> apbRsp.pready)
    else $error("no ready after setup");
  chk_ready_single: assert property (apbRsp.pready |=> !apbRsp.pready)
    else $error("ready held too long");
  chk_idle_data: assert property (!apbRsp.pready |-> apbRsp.prdata == 32'h0)
    else $error("read data outside answer");
  chk_ctrl_b_zeros: assert property (
    rdSetup && apbReq.paddr == TMR8_OFS_CTRL_B |=> apbRsp.prdata[31:4] == 28'h0)
    else $error("control B upper bits not zero");
  chk_irq_reg_zeros: assert property (
    rdSetup && (apbReq.paddr == TMR8_OFS_MASK || apbReq.paddr == TMR8_OFS_FLAGS)
    |=> apbRsp.prdata[31:3] == 29'h0)
    else $error("irq register reserved bits set");
  chk_bad_addr: assert property (setup && apbReq.paddr == TMR8_OFS_ACK
    |=> apbRsp.pslverr && apbRsp.prdata == 32'h0)
    else $error("unmapped address not refused");
  chk_good_addr: assert property (setup && apbReq.paddr == TMR8_OFS_COUNT
    |=> !apbRsp.pslverr)
    else $error("mapped address refused");
  chk_enable_cause: assert property ($changed(wave.enA) |->
    $past(apbReq.pwrite) || $past(apbReq.pwrite, 2))
    else $error("output enable moved without a write");
  // Main scenarios
  cov_write_b: cover property (setup && apbReq.pwrite && apbReq.paddr == TMR8_OFS_CTRL_B);
  cov_refused: cover property (apbRsp.pslverr);
  cov_irq_b: cover property ($rose(irqReq[2]));
endmodule // tmr8_checker
`default_nettype wire

// >>> verification/tmr8_pins.sv
/* Far-side model: drives the external count pin with pulse trains.
   Assumes the bench asks for pulses with a one-cycle go strobe. */
`timescale 1ns/1ps
`default_nettype none
module tmr8_pins (
  input  wire logic       mclk,
  input  wire logic       pulseGo,
  input  wire logic [7:0] pulseCount,
  output var  logic       extCountPin,
  output var  logic       busy
);
  // Each pulse gives one rising and one falling pin edge
  initial begin
    extCountPin = 1'b0;
    busy = 1'b0;
    forever begin
      @(posedge mclk);
      if (pulseGo) begin
        busy <= 1'b1;
        for (int n = 0; n < pulseCount; n++) begin
          repeat (2) @(posedge mclk);
          extCountPin <= 1'b1;
          repeat (2) @(posedge mclk);
          extCountPin <= 1'b0;
        end
        busy <= 1'b0;
      end
    end
  end
endmodule // tmr8_pins
`default_nettype wire

// >>> verification/tmr8_timer_bench.sv
/* Self-checking bench for tmr8_timer over APB.
   Assumes tmr8_pins as count source and tmr8_checker bound below. */
`timescale 1ns/1ps
`default_nettype none
module tmr8_timer_bench;
  import tmr8_pkg::*;
  logic          mclk;
  logic          srst;
  tmr8_apb_req_s apbReq;
  tmr8_apb_rsp_s apbRsp;
  logic          extCountPin;
  logic [2:0]    irqAck;
  tmr8_wave_s    wave;
  logic [2:0]    irqReq;
  logic          pulseGo;
  logic [7:0]    pulseCount;
  logic          busy;
  logic [31:0]   rdq;
  int            failures;
  int            tests_run;
  int            cycles;
  tmr8_timer tmr8_timer_inst (.mclk(mclk), .srst(srst), .apbReq(apbReq), .apbRsp(apbRsp),
    .extCountPin(extCountPin), .irqAck(irqAck), .wave(wave), .irqReq(irqReq));
  tmr8_pins tmr8_pins_inst (.mclk(mclk), .pulseGo(pulseGo), .pulseCount(pulseCount),
    .extCountPin(extCountPin), .busy(busy));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: {24'h0, d}};
    @(posedge mclk);
    apbReq.penable <= 1'b1;
    @(posedge mclk);
    while (apbRsp.pready !== 1'b1 && n < 20) begin
      @(posedge mclk);
      n++;
    end
    rdq = apbRsp.prdata;
    if (n == 20) failures++;
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    check(rdq, {24'h0, e});
  endtask
  task automatic pulses(input logic [7:0] k);
    int n;
    n = 0;
    pulseCount <= k;
    pulseGo <= 1'b1;
    @(posedge mclk);
    pulseGo <= 1'b0;
    repeat (2) @(posedge mclk);
    while (busy && n < 200) begin
      @(posedge mclk);
      n++;
    end
    repeat (3) @(posedge mclk);
  endtask
  task automatic t_regs();
    rd(TMR8_OFS_CTRL_B, 8'h00);
    rd(TMR8_OFS_MASK, 8'h00);
    rd(TMR8_OFS_COUNT, 8'h00);
    wr(TMR8_OFS_CTRL_B, 8'hFF);
    rd(TMR8_OFS_CTRL_B, 8'h0F);
    wr(TMR8_OFS_CTRL_B, 8'h00);
    wr(TMR8_OFS_MASK, 8'hFF);
    rd(TMR8_OFS_MASK, 8'h07);
    rd(TMR8_OFS_ACK, 8'h00);
    $display("regs test done");
  endtask
  task automatic t_force();
    logic [1:0] om [4] = '{2'h1, 2'h3, 2'h2, 2'h1};
    logic e;
    e = 1'b0;
    wr(TMR8_OFS_COUNT, 8'h09);
    foreach (om[i]) begin
      wr(TMR8_OFS_CTRL_A, {om[i], 6'h02});
      wr(TMR8_OFS_CTRL_B, 8'h80);
      e = (om[i] == TMR8_OM_TOGGLE) ? !e : (om[i] == TMR8_OM_SET);
      repeat (2) @(posedge mclk);
      check(wave.outA, e);
    end
    rd(TMR8_OFS_COUNT, 8'h09);
    rd(TMR8_OFS_FLAGS, 8'h00);
    wr(TMR8_OFS_CTRL_A, 8'h12);
    wr(TMR8_OFS_CTRL_B, 8'h40);
    repeat (2) @(posedge mclk);
    check(wave.outB, 1'b1);
    check(wave.enB, 1'b1);
    check(wave.enA, 1'b0);
    // Fast PWM: strobe written on purpose to see it ignored
    wr(TMR8_OFS_CTRL_A, 8'h23);
    wr(TMR8_OFS_CTRL_B, 8'h40);
    repeat (2) @(posedge mclk);
    check(wave.outB, 1'b1);
    // Ordinary software in a PWM mode keeps both strobes low
    wr(TMR8_OFS_CTRL_B, 8'h00);
    wr(TMR8_OFS_CTRL_A, 8'h00);
    $display("force test done");
  endtask
  task automatic t_clocks();
    int divs [5] = '{1, 8, 64, 256, 1024};
    int div;
    int w;
    for (int cs = 1; cs < 6; cs++) begin
      div = divs[cs - 1];
      w = 4 * div;
      wr(TMR8_OFS_COUNT, 8'h00);
      wr(TMR8_OFS_CTRL_B, 8'(cs));
      repeat (w) @(posedge mclk);
      wr(TMR8_OFS_CTRL_B, 8'h00);
      apb(1'b0, TMR8_OFS_COUNT, 8'h00);
      check(rdq * div >= w - div && rdq * div <= w + div + 6, 1'b1);
      // Stopped clock: the count must not move
      repeat (8) @(posedge mclk);
      rd(TMR8_OFS_COUNT, rdq[7:0]);
    end
    for (int cs = 6; cs < 8; cs++) begin
      wr(TMR8_OFS_COUNT, 8'h00);
      wr(TMR8_OFS_CTRL_B, 8'(cs));
      pulses(8'h05);
      rd(TMR8_OFS_COUNT, 8'h05);
    end
    $display("clock test done");
  endtask
  task automatic t_flags();
    wr(TMR8_OFS_FLAGS, 8'h07);
    wr(TMR8_OFS_GIE, 8'h01);
    wr(TMR8_OFS_CMP_A, 8'h04);
    wr(TMR8_OFS_CMP_B, 8'h06);
    wr(TMR8_OFS_COUNT, 8'h03);
    pulses(8'h04);
    rd(TMR8_OFS_FLAGS, 8'h06);
    check(irqReq, 3'h6);
    wr(TMR8_OFS_FLAGS, 8'h02);
    rd(TMR8_OFS_FLAGS, 8'h04);
    irqAck <= 3'h4;
    @(posedge mclk);
    irqAck <= 3'h0;
    rd(TMR8_OFS_FLAGS, 8'h00);
    wr(TMR8_OFS_COUNT, 8'h04);
    pulses(8'h01);
    rd(TMR8_OFS_FLAGS, 8'h00);
    wr(TMR8_OFS_COUNT, 8'hFF);
    pulses(8'h01);
    rd(TMR8_OFS_FLAGS, 8'h01);
    check(irqReq, 3'h1);
    wr(TMR8_OFS_MASK, 8'h00);
    repeat (2) @(posedge mclk);
    check(irqReq, 3'h0);
    $display("flag test done");
  endtask
  task automatic test_done();
    $display("checks %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ----------------------------------------
  // Clock, timeout and main sequence
  // ----------------------------------------
  initial begin
    mclk = 1'b0;
    forever #5 mclk = !mclk;
  end
  // Cut a hang short
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      test_done();
    end
  end
  initial begin
    {srst, apbReq, irqAck, pulseGo, pulseCount} = '0;
    srst = 1'b1;
    repeat (6) @(posedge mclk);
    srst <= 1'b0;
    t_regs();
    t_force();
    t_clocks();
    t_flags();
    test_done();
  end
endmodule // tmr8_timer_bench
bind tmr8_timer tmr8_checker tmr8_checker_inst (.mclk(mclk), .srst(srst),
  .apbReq(apbReq), .apbRsp(apbRsp), .extCountPin(extCountPin), .irqAck(irqAck),
  .wave(wave), .irqReq(irqReq));
`default_nettype wire
